// [vat_regs.svh]
// Register selects, entry fields, address fields and limits of the translator.
`ifndef VAT_REGS_SVH
`define VAT_REGS_SVH

// ----------------------------------------------------------------------------
// Privileged register selects
// ----------------------------------------------------------------------------
`define VAT_SEL_SYS_BASE   2'h0
`define VAT_SEL_SYS_LEN    2'h1
`define VAT_SEL_LOW_BASE   2'h2
`define VAT_SEL_LOW_LEN    2'h3

// ----------------------------------------------------------------------------
// Page entry fields
// ----------------------------------------------------------------------------
`define VAT_PTE_VALID      31
`define VAT_PTE_PROT_HI    30
`define VAT_PTE_PROT_LO    27
`define VAT_PTE_MODIFY     26
`define VAT_PTE_FRAME_HI   20

// ----------------------------------------------------------------------------
// Virtual address fields
// ----------------------------------------------------------------------------
`define VAT_REG_HI         31
`define VAT_REG_LO         30
`define VAT_VPN_HI         29
`define VAT_VPN_LO         9
`define VAT_BYTE_HI        8
`define VAT_REGION_LOW     2'h0
`define VAT_REGION_SYS     2'h2

// ----------------------------------------------------------------------------
// Register limits and masks
// ----------------------------------------------------------------------------
`define VAT_LOW_BASE_MIN   32'h80000000
`define VAT_LOW_LEN_MASK   32'hF8FFFFFF
`define VAT_LEN_MASK       32'h003FFFFF
`define VAT_RESET_VAL      32'h00000000

`endif

// [vat_pkg.sv]
// Types shared by the address translator modules.
package vat_pkg;

   // -------------------------------------------------------------------------
   // Modes, accesses and walk states
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      VAT_MODE_KERNEL = 2'h0,
      VAT_MODE_EXEC   = 2'h1,
      VAT_MODE_SUPER  = 2'h2,
      VAT_MODE_USER   = 2'h3
   } vat_mode_e;

   typedef enum logic [1:0] {
      VAT_ACC_READ    = 2'b00,
      VAT_ACC_WRITE   = 2'b01,
      VAT_ACC_MODIFY  = 2'b10,
      VAT_ACC_PROBE_W = 2'b11
   } vat_access_e;

   typedef enum logic [1:0] {
      VAT_ST_IDLE    = 2'b00,
      VAT_ST_SYS_PTE = 2'b01,
      VAT_ST_PTE     = 2'b10,
      VAT_ST_MOD_WR  = 2'b11
   } vat_state_e;

   // -------------------------------------------------------------------------
   // Registered state of the translator, apart from the reset synchroniser
   // -------------------------------------------------------------------------
   typedef struct packed {
      vat_state_e  state;
      logic [31:0] vaddr;
      vat_access_e acc;
      vat_mode_e   mode;
      logic [31:0] pte_va;
      logic [31:0] sys_base;
      logic [31:0] sys_len;
      logic [31:0] low_base;
      logic [31:0] low_len;
      logic        mem_req;
      logic        mem_we;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic        busy;
      logic        done;
      logic [31:0] pa;
      logic        f_access;
      logic        f_length;
      logic        f_not_valid;
      logic        f_pte_ref;
      logic        probe_ok;
      logic [31:0] rdata;
      logic        rsvd_fault;
   } vat_state_s;

endpackage

// [vat_prot_if.sv]
// Carrier between the walker and the protection checker.
`timescale 1ns/100ps
interface vat_prot_if;
   import vat_pkg::*;
   logic [3:0] code;
   vat_mode_e  mode;
   logic       write;
   logic       allow;
   modport req (output code, output mode, output write, input allow);
   modport chk (input code, input mode, input write, output allow);
endinterface

// [vat_prot_check.sv]
// Protection code check of one page entry against mode and access.
`timescale 1ns/100ps
module vat_prot_check
   import vat_pkg::*;
(
   // Check request and answer
   vat_prot_if.chk p
);

   logic [2:0] rd_lim;
   logic [2:0] wr_lim;

   // -------------------------------------------------------------------------
   // Number of modes, from kernel upward, that may read and write
   // -------------------------------------------------------------------------
   always_comb begin
      case (p.code)
         4'h2:    begin rd_lim = 3'h1; wr_lim = 3'h1; end
         4'h3:    begin rd_lim = 3'h1; wr_lim = 3'h0; end
         4'h4:    begin rd_lim = 3'h4; wr_lim = 3'h4; end
         4'h5:    begin rd_lim = 3'h2; wr_lim = 3'h2; end
         4'h6:    begin rd_lim = 3'h2; wr_lim = 3'h1; end
         4'h7:    begin rd_lim = 3'h2; wr_lim = 3'h0; end
         4'h8:    begin rd_lim = 3'h3; wr_lim = 3'h3; end
         4'h9:    begin rd_lim = 3'h3; wr_lim = 3'h2; end
         4'hA:    begin rd_lim = 3'h3; wr_lim = 3'h1; end
         4'hB:    begin rd_lim = 3'h3; wr_lim = 3'h0; end
         4'hC:    begin rd_lim = 3'h4; wr_lim = 3'h3; end
         4'hD:    begin rd_lim = 3'h4; wr_lim = 3'h2; end
         4'hE:    begin rd_lim = 3'h4; wr_lim = 3'h1; end
         4'hF:    begin rd_lim = 3'h4; wr_lim = 3'h0; end
         default: begin rd_lim = 3'h0; wr_lim = 3'h0; end
      endcase
   end

   assign p.allow = ({1'b0, p.mode} < (p.write ? wr_lim : rd_lim));

endmodule

// [vat_translator.sv]
// Virtual to physical address translator with page table walk.
`timescale 1ns/100ps
`include "vat_regs.svh"

module vat_translator
   import vat_pkg::*;
#(
   parameter bit LARGE = 1'b1
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Translation request
   input  wire logic        req_valid,
   input  wire logic [31:0] req_vaddr,
   input  wire vat_access_e req_access,
   input  wire vat_mode_e   req_mode,
   input  wire logic        map_enable_bit,
   // Translation answer
   output logic             busy,
   output logic             done,
   output logic [31:0]      pa,
   output logic [31:0]      fault_vaddr,
   output logic             fault_access,
   output logic             fault_length,
   output logic             fault_not_valid,
   output logic             fault_pte_ref,
   output logic             probe_ok,
   // Privileged register port
   input  wire logic        privileged_register_write,
   input  wire logic        privileged_register_read,
   input  wire logic [1:0]  priv_sel,
   input  wire logic [31:0] priv_wdata,
   output logic [31:0]      priv_rdata,
   output logic             priv_rsvd_fault,
   // Memory port
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata
);

   localparam int          PA_W       = LARGE ? 30 : 24;
   localparam int          FRAME_W    = LARGE ? 21 : 15;
   localparam logic [31:0] PA_MASK    = 32'((64'h1 << PA_W) - 64'h1);
   localparam logic [20:0] FRAME_MASK = 21'((64'h1 << FRAME_W) - 64'h1);

   logic       rst_meta_q;
   logic       rst_sync_q;
   vat_state_s s_q;
   vat_state_s s_d;
   vat_prot_if prot ();

   logic [1:0]  region;
   logic [31:0] vpn_ext;
   logic [31:0] sys_fetch;
   logic [31:0] low_pte_va;
   logic [31:0] low_vpn_ext;
   logic [31:0] low_fetch;
   logic [31:0] frame_pa;
   logic        pte_valid;
   logic        writes;

   // -------------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // -------------------------------------------------------------------------
   // Address arithmetic
   // -------------------------------------------------------------------------
   assign region      = req_vaddr[`VAT_REG_HI:`VAT_REG_LO];
   assign vpn_ext     = {11'h000, req_vaddr[`VAT_VPN_HI:`VAT_VPN_LO]};
   assign sys_fetch   = (s_q.sys_base + (vpn_ext << 2)) & PA_MASK;
   assign low_pte_va  = s_q.low_base + (vpn_ext << 2);
   assign low_vpn_ext = {11'h000, low_pte_va[`VAT_VPN_HI:`VAT_VPN_LO]};
   assign low_fetch   = (s_q.sys_base + (low_vpn_ext << 2)) & PA_MASK;
   assign frame_pa = {2'h0, mem_rdata[`VAT_PTE_FRAME_HI:0] & FRAME_MASK,
                      9'h000};
   assign pte_valid = mem_rdata[`VAT_PTE_VALID];
   assign writes    = (s_q.acc != VAT_ACC_READ);

   // -------------------------------------------------------------------------
   // Protection check of the entry on the memory data
   // -------------------------------------------------------------------------
   assign prot.code  = mem_rdata[`VAT_PTE_PROT_HI:`VAT_PTE_PROT_LO];
   assign prot.mode  = (s_q.state == VAT_ST_SYS_PTE) ? VAT_MODE_KERNEL
                                                     : s_q.mode;
   assign prot.write = (s_q.state == VAT_ST_SYS_PTE) ? 1'b0 : writes;

   vat_prot_check u_prot (
      .p (prot.chk)
   );

   // -------------------------------------------------------------------------
   // Walk and register next state
   // -------------------------------------------------------------------------
   always_comb begin
      s_d            = s_q;
      s_d.done       = 1'b0;
      s_d.rsvd_fault = 1'b0;
      if (privileged_register_write) begin
         case (priv_sel)
            `VAT_SEL_SYS_BASE: s_d.sys_base = priv_wdata;
            `VAT_SEL_SYS_LEN:  s_d.sys_len  = priv_wdata & `VAT_LEN_MASK;
            `VAT_SEL_LOW_BASE: begin
               if (priv_wdata < `VAT_LOW_BASE_MIN) begin
                  s_d.rsvd_fault = 1'b1;
               end else begin
                  s_d.low_base = priv_wdata;
               end
            end
            default: s_d.low_len = priv_wdata & `VAT_LOW_LEN_MASK;
         endcase
      end
      if (privileged_register_read) begin
         case (priv_sel)
            `VAT_SEL_SYS_BASE: s_d.rdata = s_q.sys_base;
            `VAT_SEL_SYS_LEN:  s_d.rdata = s_q.sys_len;
            `VAT_SEL_LOW_BASE: s_d.rdata = s_q.low_base;
            default:           s_d.rdata = s_q.low_len;
         endcase
      end
      case (s_q.state)
         VAT_ST_IDLE: begin
            if (req_valid) begin
               s_d.vaddr       = req_vaddr;
               s_d.acc         = req_access;
               s_d.mode        = req_mode;
               s_d.f_access    = 1'b0;
               s_d.f_length    = 1'b0;
               s_d.f_not_valid = 1'b0;
               s_d.f_pte_ref   = 1'b0;
               s_d.probe_ok    = 1'b0;
               s_d.pa          = `VAT_RESET_VAL;
               s_d.busy        = 1'b1;
               if (!map_enable_bit) begin
                  s_d.pa       = req_vaddr & PA_MASK;
                  s_d.probe_ok = 1'b1;
                  s_d.done     = 1'b1;
                  s_d.busy     = 1'b0;
               end else if (region == `VAT_REGION_SYS &&
                            vpn_ext < s_q.sys_len) begin
                  s_d.mem_addr = sys_fetch;
                  s_d.mem_req  = 1'b1;
                  s_d.state    = VAT_ST_PTE;
               end else if (region == `VAT_REGION_LOW &&
                            vpn_ext < s_q.low_len &&
                            low_pte_va[`VAT_REG_HI:`VAT_REG_LO] ==
                            `VAT_REGION_SYS &&
                            low_vpn_ext < s_q.sys_len) begin
                  s_d.pte_va   = low_pte_va;
                  s_d.mem_addr = low_fetch;
                  s_d.mem_req  = 1'b1;
                  s_d.state    = VAT_ST_SYS_PTE;
               end else begin
                  s_d.f_pte_ref = (region == `VAT_REGION_LOW) &&
                                  (vpn_ext < s_q.low_len);
                  s_d.f_length  = (req_access != VAT_ACC_PROBE_W);
                  s_d.f_access  = (req_access != VAT_ACC_PROBE_W);
                  s_d.done      = 1'b1;
                  s_d.busy      = 1'b0;
               end
            end
         end
         VAT_ST_SYS_PTE: begin
            if (mem_ack) begin
               s_d.mem_req = 1'b0;
               if (prot.allow && pte_valid) begin
                  s_d.mem_addr = (frame_pa | {23'h000000,
                                 s_q.pte_va[`VAT_BYTE_HI:0]}) & PA_MASK;
                  s_d.mem_req  = 1'b1;
                  s_d.state    = VAT_ST_PTE;
               end else begin
                  s_d.f_pte_ref   = (s_q.acc != VAT_ACC_PROBE_W);
                  s_d.f_access    = !prot.allow &&
                                    (s_q.acc != VAT_ACC_PROBE_W);
                  s_d.f_not_valid = prot.allow &&
                                    (s_q.acc != VAT_ACC_PROBE_W);
                  s_d.done        = 1'b1;
                  s_d.busy        = 1'b0;
                  s_d.state       = VAT_ST_IDLE;
               end
            end
         end
         VAT_ST_PTE: begin
            if (mem_ack) begin
               s_d.mem_req = 1'b0;
               s_d.state   = VAT_ST_IDLE;
               s_d.done    = 1'b1;
               s_d.busy    = 1'b0;
               if (s_q.acc == VAT_ACC_PROBE_W) begin
                  s_d.probe_ok = prot.allow;
               end else if (!prot.allow) begin
                  s_d.f_access = 1'b1;
               end else if (!pte_valid) begin
                  s_d.f_not_valid = 1'b1;
               end else begin
                  s_d.pa = (frame_pa | {23'h000000,
                           s_q.vaddr[`VAT_BYTE_HI:0]}) & PA_MASK;
                  if (writes && !mem_rdata[`VAT_PTE_MODIFY]) begin
                     s_d.mem_wdata = mem_rdata |
                                     (32'h1 << `VAT_PTE_MODIFY);
                     s_d.mem_we    = 1'b1;
                     s_d.mem_req   = 1'b1;
                     s_d.done      = 1'b0;
                     s_d.busy      = 1'b1;
                     s_d.state     = VAT_ST_MOD_WR;
                  end
               end
            end
         end
         VAT_ST_MOD_WR: begin
            if (mem_ack) begin
               s_d.mem_req = 1'b0;
               s_d.mem_we  = 1'b0;
               s_d.done    = 1'b1;
               s_d.busy    = 1'b0;
               s_d.state   = VAT_ST_IDLE;
            end
         end
         default: s_d.state = VAT_ST_IDLE;
      endcase
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy            = s_q.busy;
   assign done            = s_q.done;
   assign pa              = s_q.pa;
   assign fault_vaddr     = s_q.vaddr;
   assign fault_access    = s_q.f_access;
   assign fault_length    = s_q.f_length;
   assign fault_not_valid = s_q.f_not_valid;
   assign fault_pte_ref   = s_q.f_pte_ref;
   assign probe_ok        = s_q.probe_ok;
   assign priv_rdata      = s_q.rdata;
   assign priv_rsvd_fault = s_q.rsvd_fault;
   assign mem_req         = s_q.mem_req;
   assign mem_we          = s_q.mem_we;
   assign mem_addr        = s_q.mem_addr;
   assign mem_wdata       = s_q.mem_wdata;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_q);

   logic take;
   assign take = (s_q.state == VAT_ST_IDLE) && req_valid && map_enable_bit;

   a_sys_len_fault: assert property (
      take && region == `VAT_REGION_SYS && vpn_ext >= s_q.sys_len &&
      req_access != VAT_ACC_PROBE_W |=> done && fault_length && !mem_req)
      else $error("system length violation not reported");
   a_reserved_region: assert property (
      take && region == 2'h3 && req_access != VAT_ACC_PROBE_W
      |=> done && fault_length)
      else $error("fourth region not refused");
   a_sys_fetch_addr: assert property (
      take && region == `VAT_REGION_SYS && vpn_ext < s_q.sys_len
      |=> mem_req && !mem_we && mem_addr == $past(sys_fetch))
      else $error("system entry fetched at wrong address");
   a_prot_first: assert property (
      s_q.state == VAT_ST_PTE && mem_ack && !prot.allow &&
      s_q.acc != VAT_ACC_PROBE_W |=> done && fault_access && !fault_not_valid)
      else $error("protection not checked before validity");
   a_modify_set: assert property (
      s_q.state == VAT_ST_PTE && mem_ack && prot.allow && pte_valid &&
      writes && !mem_rdata[`VAT_PTE_MODIFY] && s_q.acc != VAT_ACC_PROBE_W
      |=> mem_req && mem_we && mem_wdata[`VAT_PTE_MODIFY] && !done)
      else $error("modify flag not written back");
   a_base_refuse: assert property (
      privileged_register_write && priv_sel == `VAT_SEL_LOW_BASE &&
      !priv_wdata[`VAT_REG_HI]
      |=> priv_rsvd_fault && s_q.low_base == $past(s_q.low_base))
      else $error("low region base accepted a bad value");
   a_len_bits_zero: assert property (
      privileged_register_read && priv_sel == `VAT_SEL_LOW_LEN
      |=> priv_rdata[26:24] == 3'h0)
      else $error("low region length bits 26:24 not zero");
   a_map_off_pass: assert property (
      s_q.state == VAT_ST_IDLE && req_valid && !map_enable_bit
      |=> done && pa == ($past(req_vaddr) & PA_MASK) && !fault_access)
      else $error("mapping off did not pass the address");
   a_kernel_fetch: assert property (
      s_q.state == VAT_ST_SYS_PTE && mem_ack && prot.code > 4'h1
      |-> prot.allow)
      else $error("process entry fetch not a kernel read");
   a_fault_quiet: assert property (
      done && (fault_access || fault_not_valid) |-> !mem_req &&
      pa == `VAT_RESET_VAL)
      else $error("fault with memory access pending");

   c_sys_ok: cover property (s_q.state == VAT_ST_PTE ##1 done &&
                             !fault_access && !fault_not_valid);
   c_low_walk: cover property (s_q.state == VAT_ST_SYS_PTE ##[1:20]
                               s_q.state == VAT_ST_MOD_WR);
   c_rsvd: cover property (priv_rsvd_fault);
   c_probe: cover property (done && probe_ok && map_enable_bit);

endmodule

// [vat_mem_model.sv]
// Memory model that answers the translator's memory port.
`timescale 1ns/100ps
module vat_mem_model (
   // Clock
   input  wire logic        clk,
   // Memory port
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   logic [31:0] store [logic [31:0]];
   logic [1:0]  wait_q = 2'h0;
   initial mem_ack = 1'b0;
   initial mem_rdata = 32'h0;
   // Answers after a random wait; the data line toggles while a request waits and in the cycle after each answer.
   always @(posedge clk) begin
      if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req && wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req) begin
         mem_ack <= 1'b1;
         wait_q <= 2'($urandom % 3);
         if (mem_we) store[mem_addr] = mem_wdata;
         else mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : 32'h0;
      end
   end
endmodule

// [tb_top.sv]
// Self-checking testbench of the address translator.
`timescale 1ns/100ps
module tb_top;
   import vat_pkg::*;
   // ------------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------------
   logic        clk = 0, rst_n = 0, req_valid = 0, map_enable_bit = 0;
   logic        privileged_register_write = 0, privileged_register_read = 0;
   logic [31:0] req_vaddr = 0, priv_wdata = 0, pa, fault_vaddr, priv_rdata;
   logic [1:0]  priv_sel = 0;
   vat_access_e req_access = VAT_ACC_READ;
   vat_mode_e   req_mode = VAT_MODE_KERNEL;
   logic        busy, done, fault_access, fault_length, fault_not_valid;
   logic        fault_pte_ref, probe_ok, priv_rsvd_fault;
   logic        mem_req, mem_we, mem_ack;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, va;
   logic [8:0]  o;
   logic [36:0] exp_q [$];
   logic [36:0] e;
   int          mismatches = 0, checks_done = 0;
   always #4 clk = ~clk;
   vat_translator uut (.clk, .rst_n, .req_valid, .req_vaddr, .req_access,
      .req_mode, .map_enable_bit, .busy, .done, .pa, .fault_vaddr,
      .fault_access, .fault_length, .fault_not_valid, .fault_pte_ref,
      .probe_ok, .privileged_register_write, .privileged_register_read,
      .priv_sel, .priv_wdata, .priv_rdata, .priv_rsvd_fault, .mem_req,
      .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
   vat_mem_model mem_i (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata,
      .mem_ack, .mem_rdata);
   // ------------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------------
   task automatic cmp(input logic [36:0] g, input logic [36:0] x);
      checks_done++;
      if (g !== x) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic wreg(input logic [1:0] s, input logic [31:0] d);
      @(posedge clk);
      privileged_register_write <= 1'b1;
      priv_sel <= s;
      priv_wdata <= d;
      @(posedge clk);
      privileged_register_write <= 1'b0;
   endtask
   task automatic rreg(input logic [1:0] s, input logic [31:0] x);
      @(posedge clk);
      privileged_register_read <= 1'b1;
      priv_sel <= s;
      @(posedge clk);
      privileged_register_read <= 1'b0;
      @(negedge clk);
      cmp({5'h0, priv_rdata}, {5'h0, x});
   endtask
   task automatic xlate(input logic [31:0] a, input vat_access_e ac,
         input vat_mode_e m, input logic me, input logic [36:0] x);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_vaddr <= a;
      req_access <= ac;
      req_mode <= m;
      map_enable_bit <= me;
      exp_q.push_back(x);
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      cmp({36'h0, busy ^ done}, 37'h1);
      while (done !== 1'b1 && ++n < 60) @(negedge clk);
      if (n >= 60) mismatches++;
      cmp({5'h0, fault_vaddr}, {5'h0, a});
   endtask
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Compares every finished translation with the oldest expectation.
   always @(negedge clk) begin
      if (done === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 37'hX;
         cmp({fault_pte_ref, probe_ok, fault_access, fault_length,
              fault_not_valid, pa}, e);
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end
   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial begin
      void'($urandom(32'h5FE7AB93));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      mem_i.store[32'h100C] = 32'hA5E01234;
      mem_i.store[32'h1010] = 32'hA1E00055;
      mem_i.store[32'h1014] = 32'hF8000077;
      mem_i.store[32'h1018] = 32'h20000099;
      mem_i.store[32'h101C] = 32'h00000000;
      mem_i.store[32'h1020] = 32'hA0000040;
      mem_i.store[32'h8008] = 32'hA4000077;
      mem_i.store[32'h1024] = 32'hCC000011;
      mem_i.store[32'h800C] = 32'hA0000033;
      wreg(2'h0, 32'h1000);
      wreg(2'h1, 32'h10);
      rreg(2'h1, 32'h10);
      wreg(2'h3, 32'h07000010);
      rreg(2'h3, 32'h10);
      wreg(2'h2, 32'h80001000);
      wreg(2'h2, 32'h7FFFFFFC);
      @(negedge clk);
      cmp({36'h0, priv_rsvd_fault}, 37'h1);
      rreg(2'h2, 32'h80001000);
      for (int i = 0; i < 4; i++) begin
         va = $urandom;
         xlate(va, VAT_ACC_WRITE, VAT_MODE_USER, 0, {7'h20, va[29:0]});
      end
      o = 9'($urandom);
      xlate({23'h400003, o}, VAT_ACC_READ, VAT_MODE_USER, 1,
            {5'h0, 32'h246800 | o});
      xlate({23'h400004, o}, VAT_ACC_WRITE, VAT_MODE_KERNEL, 1,
            {5'h0, 32'hAA00 | o});
      cmp({5'h0, mem_i.store[32'h1010]}, 37'h0A5E00055);
      xlate({23'h400005, o}, VAT_ACC_MODIFY, VAT_MODE_USER, 1,
            {5'h04, 32'h0});
      xlate({23'h400005, o}, VAT_ACC_READ, VAT_MODE_EXEC, 1,
            {5'h0, 32'hEE00 | o});
      xlate({23'h400009, o}, VAT_ACC_WRITE, VAT_MODE_SUPER, 1,
            {5'h04, 32'h0});
      xlate({23'h400009, o}, VAT_ACC_WRITE, VAT_MODE_EXEC, 1,
            {5'h0, 32'h2200 | o});
      xlate({23'h400006, o}, VAT_ACC_READ, VAT_MODE_USER, 1,
            {5'h01, 32'h0});
      xlate({23'h400006, o}, VAT_ACC_PROBE_W, VAT_MODE_USER, 1,
            {7'h20, 30'h0});
      xlate({23'h400007, o}, VAT_ACC_READ, VAT_MODE_KERNEL, 1,
            {5'h04, 32'h0});
      xlate({23'h400010, o}, VAT_ACC_READ, VAT_MODE_KERNEL, 1,
            {5'h06, 32'h0});
      xlate({23'h400010, o}, VAT_ACC_PROBE_W, VAT_MODE_USER, 1,
            37'h0);
      xlate({23'h600000, o}, VAT_ACC_READ, VAT_MODE_KERNEL, 1,
            {5'h06, 32'h0});
      xlate({23'h2, o}, VAT_ACC_READ, VAT_MODE_USER, 1,
            {5'h0, 32'hEE00 | o});
      xlate({23'h3, o}, VAT_ACC_WRITE, VAT_MODE_USER, 1,
            {5'h0, 32'h6600 | o});
      cmp({5'h0, mem_i.store[32'h800C]}, 37'h0A4000033);
      xlate({23'h10, o}, VAT_ACC_READ, VAT_MODE_USER, 1,
            {5'h06, 32'h0});
      wreg(2'h2, 32'h80000E00);
      xlate({23'h0, o}, VAT_ACC_READ, VAT_MODE_USER, 1,
            {7'h50, 30'h0});
      complete_run();
   end
endmodule
